// *** inc/mmag_pkg.sv ***
package mmag_pkg;

    // bus geometry
    localparam int MMAG_ADDR_W = 24;
    localparam int MMAG_DATA_W = 8;
    localparam int MMAG_CODE_W = 4;
    localparam int MMAG_NMST = 3;
    localparam int MMAG_NTGT = 3;

    // master index, lower index wins arbitration
    localparam int MMAG_MST_DBG = 0;
    localparam int MMAG_MST_CPU = 1;
    localparam int MMAG_MST_ADC = 2;

    // target index
    localparam int MMAG_TGT_REG = 0;
    localparam int MMAG_TGT_RAM = 1;
    localparam int MMAG_TGT_NVM = 2;

    // address map of the 16 MB space
    localparam logic [23:0] MMAG_REG_BASE = 24'h00_0000;
    localparam logic [23:0] MMAG_REG_LAST = 24'h00_0fff;
    localparam logic [23:0] MMAG_RAM_BASE = 24'h00_1000;
    localparam logic [23:0] MMAG_RAM_LAST = 24'h00_ffff;
    localparam logic [23:0] MMAG_NVM_BASE = 24'h80_0000;
    localparam logic [23:0] MMAG_NVM_LAST = 24'hff_ffff;

    // register offsets
    localparam logic [7:0] MMAG_OFS_MODE = 8'h70;
    localparam logic [7:0] MMAG_OFS_LOG_HI = 8'h80;
    localparam logic [7:0] MMAG_OFS_LOG_LO = 8'h81;
    localparam logic [7:0] MMAG_OFS_FLG_HI = 8'h82;
    localparam logic [7:0] MMAG_OFS_FLG_LO = 8'h83;
    localparam logic [7:0] MMAG_OFS_PC_UP = 8'h85;
    localparam logic [7:0] MMAG_OFS_PC_MID = 8'h86;
    localparam logic [7:0] MMAG_OFS_PC_LOW = 8'h87;

    // field positions
    localparam int MMAG_MODE_BIT = 7;
    localparam int MMAG_USER_BIT = 7;
    localparam int MMAG_XMASK_BIT = 6;
    localparam int MMAG_IMASK_BIT = 4;

    // mode bit values
    localparam logic MMAG_MODE_SPECIAL = 1'b0;
    localparam logic MMAG_MODE_NORMAL = 1'b1;

    localparam logic [7:0] MMAG_BYTE_ONES = 8'hff;
    localparam logic [7:0] MMAG_BYTE_ZERO = 8'h00;

    // initiator codes
    localparam logic [3:0] MMAG_ITR_NONE = 4'h0;
    localparam logic [3:0] MMAG_ITR_CPU = 4'h1;
    localparam logic [3:0] MMAG_ITR_ADC = 4'h3;

    // target codes
    localparam logic [3:0] MMAG_TGC_NONE = 4'h0;
    localparam logic [3:0] MMAG_TGC_REG = 4'h1;
    localparam logic [3:0] MMAG_TGC_RAM = 4'h2;
    localparam logic [3:0] MMAG_TGC_NVM = 4'h6;

    // access type codes
    localparam logic [3:0] MMAG_ACC_NONE = 4'h0;
    localparam logic [3:0] MMAG_ACC_OPCODE = 4'h1;
    localparam logic [3:0] MMAG_ACC_VECTOR = 4'h2;
    localparam logic [3:0] MMAG_ACC_LOAD = 4'h3;
    localparam logic [3:0] MMAG_ACC_STORE = 4'h4;

    // error type codes
    localparam logic [3:0] MMAG_ERR_ILLEGAL = 4'h1;
    localparam logic [3:0] MMAG_ERR_ECC = 4'h2;

    typedef struct packed {
        logic valid;
        logic [23:0] addr;
        logic [3:0] acc;
        logic [7:0] wdata;
    } mmag_req_type;

    typedef struct packed {
        logic valid;
        logic [1:0] master;
        logic [23:0] addr;
        logic [3:0] acc;
        logic [7:0] wdata;
    } mmag_fwd_type;

    typedef struct packed {
        logic valid;
        logic [3:0] initiator;
        logic [3:0] target;
        logic [3:0] acc;
    } mmag_ecc_type;

    typedef struct packed {
        logic user;
        logic x_mask;
        logic i_mask;
    } mmag_ccr_type;

endpackage

// *** core/mmag_arbiter.sv ***
`timescale 1ns/100ps
`default_nettype none

// fixed priority: the lowest requesting index is granted
module mmag_arbiter #(
    parameter int NREQ = 3
) (
    input wire logic [NREQ-1:0] req,
    output logic [NREQ-1:0] gnt
);

    logic taken;

    always_comb begin
        gnt = '0;
        taken = 1'b0;
        for (int i = 0; i < NREQ; i++) begin
            if (req[i] && !taken) begin
                gnt[i] = 1'b1;
                taken = 1'b1;
            end
        end
    end

endmodule

`default_nettype wire

// *** core/mmag_top.sv ***
// Decided for this implementation: strobed register access.
`timescale 1ns/100ps
`default_nettype none

// Behaviour
// - The mode bit takes the synchronised mode select pin on the release of the reset pin.
// - Software may only move the mode from special single-chip to normal single-chip.
// - The external reset pin is active low.
// - In stop mode no access is granted or forwarded.
// - All three masters see one 24-bit address map of memories and peripherals.
// - Each target has its own arbiter so masters on different targets proceed together.
// - Every core or ADC access violation raises a machine exception pulse to the core; debug master violations do not.
// - A violation records its cause, the core program counter and core flags.
// - Unmapped addresses, stores to nonvolatile memory and misplaced vector fetches are illegal.
// - Illegal accesses and uncorrectable ECC errors are both handled as violations.
// - The ADC is a master of its own and reaches the map through the same per-target arbiters as the others.
// - A non-zero log freezes itself, the program counter and the flags until cleared.
// - Writing all ones to both log bytes clears both to zero.
// - The log holds initiator code and target code in its high byte.
// - The log holds access type code and error type code in its low byte.
module mmag_top
    import mmag_pkg::*;
#(
    parameter int NMST = MMAG_NMST,
    parameter int NTGT = MMAG_NTGT
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic reset_pin_n,
    input wire logic mode_select_input,
    input wire logic stop_mode,
    input wire mmag_req_type mst_req [NMST],
    output logic [NMST-1:0] mst_gnt,
    output logic [NMST-1:0] mst_err,
    input wire logic [23:0] captured_program_counter,
    input wire mmag_ccr_type cpu_ccr,
    input wire mmag_ecc_type ecc_err,
    output mmag_fwd_type tgt_req [NTGT],
    output logic machine_exception,
    output logic normal_mode,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata
);

    // pin synchronisers
    logic rst_pin_meta_r;
    logic rst_pin_sync_r;
    logic rst_pin_prev_r;
    logic mode_select_input_meta_r;
    logic mode_select_input_sync_r;
    logic pin_release;
    logic blk_rst;

    // decode and arbitration
    logic [1:0] mst_tgt [NMST];
    logic [NMST-1:0] mst_hit;
    logic [NMST-1:0] mst_illegal;
    logic [NMST-1:0] mst_legal;
    logic [NMST-1:0] arb_req [NTGT];
    logic [NMST-1:0] arb_gnt [NTGT];
    logic [NMST-1:0] gnt_any;

    // violation selection
    logic viol_valid;
    logic [3:0] viol_itr;
    logic [3:0] viol_tgt;
    logic [3:0] viol_acc;
    logic [3:0] viol_err;

    // registers
    logic mode_r;
    logic [7:0] log_hi_r;
    logic [7:0] log_lo_r;
    mmag_ccr_type flags_r;
    logic [23:0] pc_r;
    logic hi_ones_r;
    logic lo_ones_r;
    logic clear_now;
    logic log_nonzero;
    logic log_take;
    logic exc_r;
    logic [7:0] rdata_r;

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            rst_pin_meta_r <= 1'b0;
            rst_pin_sync_r <= 1'b0;
            rst_pin_prev_r <= 1'b0;
        end else begin
            rst_pin_meta_r <= reset_pin_n;
            rst_pin_sync_r <= rst_pin_meta_r;
            rst_pin_prev_r <= rst_pin_sync_r;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            mode_select_input_meta_r <= 1'b0;
            mode_select_input_sync_r <= 1'b0;
        end else begin
            mode_select_input_meta_r <= mode_select_input;
            mode_select_input_sync_r <= mode_select_input_meta_r;
        end
    end

    assign pin_release = rst_pin_sync_r && !rst_pin_prev_r;
    assign blk_rst = reset || !rst_pin_sync_r;

    function automatic logic [1:0] tgt_of(input logic [23:0] a);
        if (a >= MMAG_REG_BASE && a <= MMAG_REG_LAST) begin
            tgt_of = 2'(MMAG_TGT_REG);
        end else if (a >= MMAG_RAM_BASE && a <= MMAG_RAM_LAST) begin
            tgt_of = 2'(MMAG_TGT_RAM);
        end else begin
            tgt_of = 2'(MMAG_TGT_NVM);
        end
    endfunction

    function automatic logic [3:0] tgt_code(input logic [1:0] t, input logic hit);
        if (!hit) begin
            tgt_code = MMAG_TGC_NONE;
        end else if (t == 2'(MMAG_TGT_REG)) begin
            tgt_code = MMAG_TGC_REG;
        end else if (t == 2'(MMAG_TGT_RAM)) begin
            tgt_code = MMAG_TGC_RAM;
        end else begin
            tgt_code = MMAG_TGC_NVM;
        end
    endfunction

    genvar m;
    generate
        for (m = 0; m < NMST; m++) begin : g_mst
            assign mst_tgt[m] = tgt_of(mst_req[m].addr);
            assign mst_hit[m] = (mst_req[m].addr <= MMAG_RAM_LAST)
                || (mst_req[m].addr >= MMAG_NVM_BASE);
            assign mst_illegal[m] = mst_req[m].valid && (!mst_hit[m]
                || (mst_tgt[m] == 2'(MMAG_TGT_NVM) && mst_req[m].acc == MMAG_ACC_STORE)
                || (mst_tgt[m] != 2'(MMAG_TGT_NVM) && mst_req[m].acc == MMAG_ACC_VECTOR));
            assign mst_legal[m] = mst_req[m].valid && !mst_illegal[m] && !stop_mode;
        end
    endgenerate

    genvar t;
    generate
        for (t = 0; t < NTGT; t++) begin : g_tgt
            always_comb begin
                for (int k = 0; k < NMST; k++) begin
                    arb_req[t][k] = mst_legal[k] && (mst_tgt[k] == 2'(t));
                end
            end

            mmag_arbiter #(
                .NREQ(NMST)
            ) u_arb (
                .req(arb_req[t]),
                .gnt(arb_gnt[t])
            );

            // adc reaches targets through the same per-target path
            always_ff @(posedge sys_clk) begin
                if (blk_rst) begin
                    tgt_req[t] <= '0;
                end else begin
                    tgt_req[t].valid <= |arb_gnt[t];
                    tgt_req[t].master <= '0;
                    tgt_req[t].addr <= '0;
                    tgt_req[t].acc <= '0;
                    tgt_req[t].wdata <= '0;
                    for (int k = NMST - 1; k >= 0; k--) begin
                        if (arb_gnt[t][k]) begin
                            tgt_req[t].master <= 2'(k);
                            tgt_req[t].addr <= mst_req[k].addr;
                            tgt_req[t].acc <= mst_req[k].acc;
                            tgt_req[t].wdata <= mst_req[k].wdata;
                        end
                    end
                end
            end
        end
    endgenerate

    // illegal requests are answered at once with an error so a master never hangs
    always_comb begin
        gnt_any = '0;
        for (int j = 0; j < NTGT; j++) begin
            gnt_any = gnt_any | arb_gnt[j];
        end
    end

    assign mst_gnt = blk_rst ? '0 : (gnt_any | (mst_illegal & {NMST{!stop_mode}}));
    assign mst_err = blk_rst ? '0 : (mst_illegal & {NMST{!stop_mode}});

    // illegal access and ecc error both count; debug accesses are not logged
    always_comb begin
        viol_valid = 1'b0;
        viol_itr = MMAG_ITR_NONE;
        viol_tgt = MMAG_TGC_NONE;
        viol_acc = MMAG_ACC_NONE;
        viol_err = 4'h0;
        if (stop_mode) begin
            viol_valid = 1'b0;
        end else if (mst_illegal[MMAG_MST_CPU]) begin
            viol_valid = 1'b1;
            viol_itr = MMAG_ITR_CPU;
            viol_tgt = tgt_code(mst_tgt[MMAG_MST_CPU], mst_hit[MMAG_MST_CPU]);
            viol_acc = mst_req[MMAG_MST_CPU].acc;
            viol_err = MMAG_ERR_ILLEGAL;
        end else if (mst_illegal[MMAG_MST_ADC]) begin
            viol_valid = 1'b1;
            viol_itr = MMAG_ITR_ADC;
            viol_tgt = tgt_code(mst_tgt[MMAG_MST_ADC], mst_hit[MMAG_MST_ADC]);
            viol_acc = mst_req[MMAG_MST_ADC].acc;
            viol_err = MMAG_ERR_ILLEGAL;
        end else if (ecc_err.valid) begin
            viol_valid = 1'b1;
            viol_itr = ecc_err.initiator;
            viol_tgt = ecc_err.target;
            viol_acc = ecc_err.acc;
            viol_err = MMAG_ERR_ECC;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (blk_rst) begin
            exc_r <= 1'b0;
        end else begin
            exc_r <= viol_valid;
        end
    end

    assign machine_exception = exc_r;

    // both bytes must have seen all ones
    always_ff @(posedge sys_clk) begin
        if (blk_rst || clear_now) begin
            hi_ones_r <= 1'b0;
            lo_ones_r <= 1'b0;
        end else if (reg_wr && reg_addr == MMAG_OFS_LOG_HI) begin
            hi_ones_r <= (reg_wdata == MMAG_BYTE_ONES);
        end else if (reg_wr && reg_addr == MMAG_OFS_LOG_LO) begin
            lo_ones_r <= (reg_wdata == MMAG_BYTE_ONES);
        end
    end

    assign clear_now = reg_wr && reg_wdata == MMAG_BYTE_ONES
        && ((reg_addr == MMAG_OFS_LOG_HI && lo_ones_r)
        || (reg_addr == MMAG_OFS_LOG_LO && hi_ones_r));

    assign log_nonzero = (log_hi_r != MMAG_BYTE_ZERO) || (log_lo_r != MMAG_BYTE_ZERO);
    // a violation in the clearing cycle wins over the clear
    assign log_take = viol_valid && (!log_nonzero || clear_now);

    always_ff @(posedge sys_clk) begin
        if (blk_rst) begin
            log_hi_r <= MMAG_BYTE_ZERO;
            log_lo_r <= MMAG_BYTE_ZERO;
        end else if (log_take) begin
            log_hi_r <= {viol_itr, viol_tgt};
            log_lo_r <= {viol_acc, viol_err};
        end else if (clear_now) begin
            log_hi_r <= MMAG_BYTE_ZERO;
            log_lo_r <= MMAG_BYTE_ZERO;
        end
    end

    // pc and flags taken in the log cycle
    always_ff @(posedge sys_clk) begin
        if (blk_rst) begin
            pc_r <= '0;
            flags_r <= '0;
        end else if (log_take) begin
            pc_r <= captured_program_counter;
            flags_r <= cpu_ccr;
        end
    end

    // mode is only reset by the system reset, the pin edge loads it
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            mode_r <= MMAG_MODE_SPECIAL;
        end else if (pin_release) begin
            mode_r <= mode_select_input_sync_r;
        end else if (reg_wr && reg_addr == MMAG_OFS_MODE && rst_pin_sync_r
                     && mode_r == MMAG_MODE_SPECIAL
                     && reg_wdata[MMAG_MODE_BIT] == MMAG_MODE_NORMAL) begin
            mode_r <= MMAG_MODE_NORMAL;
        end
    end

    assign normal_mode = mode_r;

    // read data stand one cycle after the strobe; reserved offsets read zero
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            rdata_r <= MMAG_BYTE_ZERO;
        end else if (!reg_rd) begin
            rdata_r <= MMAG_BYTE_ZERO;
        end else if (reg_addr == MMAG_OFS_MODE) begin
            rdata_r <= {mode_r, 7'h00};
        end else if (reg_addr == MMAG_OFS_LOG_HI) begin
            rdata_r <= log_hi_r;
        end else if (reg_addr == MMAG_OFS_LOG_LO) begin
            rdata_r <= log_lo_r;
        end else if (reg_addr == MMAG_OFS_FLG_HI) begin
            rdata_r <= 8'(flags_r.user) << MMAG_USER_BIT;
        end else if (reg_addr == MMAG_OFS_FLG_LO) begin
            rdata_r <= (8'(flags_r.x_mask) << MMAG_XMASK_BIT)
                | (8'(flags_r.i_mask) << MMAG_IMASK_BIT);
        end else if (reg_addr == MMAG_OFS_PC_UP) begin
            rdata_r <= pc_r[23:16];
        end else if (reg_addr == MMAG_OFS_PC_MID) begin
            rdata_r <= pc_r[15:8];
        end else if (reg_addr == MMAG_OFS_PC_LOW) begin
            rdata_r <= pc_r[7:0];
        end else begin
            rdata_r <= MMAG_BYTE_ZERO;
        end
    end

    assign reg_rdata = rdata_r;

endmodule

`default_nettype wire

// *** tb/mmag_chk.sv ***
`timescale 1ns/100ps
`default_nettype none
module mmag_chk
    import mmag_pkg::*;
#(
    parameter int NMST = MMAG_NMST,
    parameter int NTGT = MMAG_NTGT
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic reset_pin_n,
    input wire logic stop_mode,
    input wire mmag_req_type mst_req [NMST],
    input wire logic [NMST-1:0] mst_gnt,
    input wire logic [NMST-1:0] mst_err,
    input wire mmag_ecc_type ecc_err,
    input wire mmag_fwd_type tgt_req [NTGT],
    input wire logic machine_exception,
    input wire logic normal_mode,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    logic [NMST-1:0] req_v;
    logic [NTGT-1:0] fwd_v;
    always_comb begin
        for (int i = 0; i < NMST; i++) req_v[i] = mst_req[i].valid;
        for (int i = 0; i < NTGT; i++) fwd_v[i] = tgt_req[i].valid;
    end
    stop_gate_a: assert property (stop_mode |-> mst_gnt == '0 && mst_err == '0)
        else $error("grant in stop mode");
    grant_cause_a: assert property ((mst_gnt & ~req_v) == '0)
        else $error("grant without request");
    err_grant_a: assert property ((mst_err & ~mst_gnt) == '0)
        else $error("error without grant");
    fwd_cause_a: assert property (|fwd_v |-> $past(|(mst_gnt & ~mst_err)))
        else $error("forward without legal grant");
    fwd_follow_a: assert property (disable iff (reset || !reset_pin_n)
        |(mst_gnt & ~mst_err) |=> |fwd_v) else $error("legal grant not forwarded");
    core_exc_a: assert property (disable iff (reset || !reset_pin_n)
        mst_err[MMAG_MST_CPU] |=> machine_exception) else $error("no exception on core error");
    ecc_exc_a: assert property (ecc_err.valid && !stop_mode |=> machine_exception)
        else $error("no exception on ecc error");
    exc_cause_a: assert property (machine_exception |-> $past(|mst_err || ecc_err.valid))
        else $error("exception without cause");
    rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside read slot");
    mode_keep_a: assert property ($fell(normal_mode) |->
        !$past(reset_pin_n, 3) || !$past(reset_pin_n, 4) || !$past(reset_pin_n, 5))
        else $error("mode left normal without pin reset");
endmodule
`default_nettype wire

// *** tb/mmag_mst_model.sv ***
`timescale 1ns/100ps
`default_nettype none
// one bus master: holds its request until granted, then scrambles the released address and write data
module mmag_mst_model
    import mmag_pkg::*;
(
    input wire logic sys_clk,
    input wire logic go,
    input wire mmag_req_type cmd,
    input wire logic gnt,
    output mmag_req_type req
);
    initial req = '0;
    always @(posedge sys_clk) begin
        if (go) begin
            req <= cmd;
        end else if (req.valid && gnt) begin
            req.valid <= 1'b0;
            req.addr <= ~req.addr;
            req.wdata <= ~req.wdata;
        end
    end
endmodule
`default_nettype wire

// *** tb/test_memory_map_access_guard.sv ***
`timescale 1ns/100ps
`default_nettype none
module test_memory_map_access_guard
    import mmag_pkg::*;
;
    logic sys_clk = 0, reset = 1, reset_pin_n = 1, mode_select_input = 0, stop_mode = 0;
    mmag_req_type mst_req [MMAG_NMST];
    mmag_req_type cmd [MMAG_NMST];
    logic [MMAG_NMST-1:0] go = '0, mst_gnt, mst_err;
    logic [23:0] pc = 24'h12_3456;
    mmag_ccr_type ccr = '{user: 1'b1, x_mask: 1'b0, i_mask: 1'b1};
    mmag_ecc_type ecc = '0;
    mmag_fwd_type tgt_req [MMAG_NTGT];
    logic machine_exception, normal_mode, reg_wr = 0, reg_rd = 0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
    int cyc = 0, err_total = 0, checks = 0, exc_at = 0;
    int gnt_at [MMAG_NMST] = '{default: 0};
    int err_at [MMAG_NMST] = '{default: 0};
    int fwd_at [MMAG_NTGT] = '{default: 0};
    logic [1:0] fwd_m [MMAG_NTGT];
    mmag_fwd_type fwd_s [MMAG_NTGT];

    always #2.5 sys_clk = ~sys_clk;

    mmag_top uut (.sys_clk(sys_clk), .reset(reset), .reset_pin_n(reset_pin_n),
        .mode_select_input(mode_select_input), .stop_mode(stop_mode), .mst_req(mst_req),
        .mst_gnt(mst_gnt), .mst_err(mst_err), .captured_program_counter(pc), .cpu_ccr(ccr),
        .ecc_err(ecc), .tgt_req(tgt_req), .machine_exception(machine_exception),
        .normal_mode(normal_mode), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

    for (genvar i = 0; i < MMAG_NMST; i++) begin : g_mst
        mmag_mst_model m (.sys_clk(sys_clk), .go(go[i]), .cmd(cmd[i]), .gnt(mst_gnt[i]),
            .req(mst_req[i]));
    end

    // timestamps of grants, errors, forwards and exceptions for timing checks
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (machine_exception) exc_at <= cyc;
        for (int i = 0; i < MMAG_NMST; i++) begin
            if (mst_gnt[i]) gnt_at[i] <= cyc;
            if (mst_err[i]) err_at[i] <= cyc;
            if (tgt_req[i].valid) fwd_at[i] <= cyc;
            if (tgt_req[i].valid) fwd_m[i] <= tgt_req[i].master;
            if (tgt_req[i].valid) fwd_s[i] <= tgt_req[i];
        end
    end

    task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(logic [7:0] a, logic [7:0] exp);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(negedge sys_clk);
        chk($sformatf("reg_%h", a), reg_rdata, exp);
    endtask
    task automatic clr();
        wr(8'h80, 8'hff);
        wr(8'h81, 8'hff);
    endtask
    // call right after a rising edge; settle() launches it
    task automatic issue(int m, logic [23:0] a, logic [3:0] acc);
        cmd[m] <= '{valid: 1'b1, addr: a, acc: acc, wdata: 8'h5a};
        go[m] <= 1'b1;
    endtask
    task automatic settle();
        @(posedge sys_clk);
        go <= '0;
        repeat (4) @(posedge sys_clk);
    endtask
    task automatic pin_pulse(logic ms);
        @(posedge sys_clk);
        mode_select_input <= ms;
        reset_pin_n <= 1'b0;
        repeat (5) @(posedge sys_clk);
        reset_pin_n <= 1'b1;
        repeat (8) @(posedge sys_clk);
    endtask

    task automatic t_regs();
        chk("normal_mode", normal_mode, 1'b0);
        rd(8'h70, 8'h00);
        for (int a = 'h80; a <= 'h87; a++) rd(a[7:0], 8'h00);
        rd(8'hf0, 8'h00);
    endtask
    task automatic t_mode();
        wr(8'h70, 8'h00);
        rd(8'h70, 8'h00);
        wr(8'h70, 8'h80);
        rd(8'h70, 8'h80);
        chk("normal_mode", normal_mode, 1'b1);
        wr(8'h70, 8'h00);
        rd(8'h70, 8'h80);
    endtask
    task automatic t_pin();
        pin_pulse(1'b0);
        chk("normal_mode", normal_mode, 1'b0);
        pin_pulse(1'b1);
        rd(8'h70, 8'h80);
    endtask
    task automatic t_route();
        @(posedge sys_clk);
        issue(0, 24'h00_0010, MMAG_ACC_LOAD);
        issue(1, 24'h00_1000, MMAG_ACC_LOAD);
        issue(2, 24'h80_0000, MMAG_ACC_LOAD);
        settle();
        chk("gnt_same_dbg", gnt_at[0], gnt_at[1]);
        chk("gnt_same_adc", gnt_at[2], gnt_at[1]);
        for (int t = 0; t < MMAG_NTGT; t++) begin
            chk("fwd_master", fwd_m[t], t);
            chk("fwd_time", fwd_at[t], gnt_at[t] + 1);
        end
        @(posedge sys_clk);
        issue(0, 24'h00_2000, MMAG_ACC_LOAD);
        issue(1, 24'h00_2001, MMAG_ACC_STORE);
        settle();
        chk("gnt_order", gnt_at[1], gnt_at[0] + 1);
        chk("fwd_last", fwd_m[1], 2'd1);
        chk("fwd_addr_reg", fwd_s[0].addr, 24'h00_0010);
        chk("fwd_addr_nvm", fwd_s[2].addr, 24'h80_0000);
        chk("fwd_addr_ram", fwd_s[1].addr, 24'h00_2001);
        chk("fwd_acc", fwd_s[1].acc, MMAG_ACC_STORE);
        chk("fwd_wdata", fwd_s[1].wdata, 8'h5a);
    endtask
    task automatic t_stop();
        int prev;
        prev = gnt_at[1];
        @(posedge sys_clk);
        stop_mode <= 1'b1;
        issue(1, 24'h00_1004, MMAG_ACC_LOAD);
        settle();
        chk("stop_hold", gnt_at[1], prev);
        stop_mode <= 1'b0;
        repeat (3) @(posedge sys_clk);
        chk("stop_release", gnt_at[1] > prev, 1);
    endtask
    task automatic t_viol();
        @(posedge sys_clk);
        issue(1, 24'h80_0000, MMAG_ACC_STORE);
        settle();
        chk("err_core", err_at[1], gnt_at[1]);
        chk("exc_time", exc_at, err_at[1] + 1);
        rd(8'h80, {MMAG_ITR_CPU, MMAG_TGC_NVM});
        rd(8'h81, {MMAG_ACC_STORE, MMAG_ERR_ILLEGAL});
        rd(8'h82, 8'h80);
        rd(8'h83, 8'h10);
        rd(8'h85, 8'h12);
        rd(8'h86, 8'h34);
        wr(8'h87, 8'h00);
        rd(8'h87, 8'h56);
        @(posedge sys_clk);
        pc <= 24'h65_4321;
        @(posedge sys_clk);
        issue(2, 24'h02_0000, MMAG_ACC_LOAD);
        settle();
        chk("exc_adc", exc_at, err_at[2] + 1);
        rd(8'h80, {MMAG_ITR_CPU, MMAG_TGC_NVM});
        wr(8'h80, 8'hff);
        rd(8'h87, 8'h56);
        wr(8'h81, 8'hff);
        rd(8'h80, 8'h00);
        rd(8'h81, 8'h00);
        @(posedge sys_clk);
        ecc <= '{valid: 1'b1, initiator: MMAG_ITR_ADC, target: MMAG_TGC_RAM, acc: MMAG_ACC_LOAD};
        @(posedge sys_clk);
        ecc <= '0;
        rd(8'h80, {MMAG_ITR_ADC, MMAG_TGC_RAM});
        rd(8'h81, {MMAG_ACC_LOAD, MMAG_ERR_ECC});
        rd(8'h85, 8'h65);
        clr();
        for (int a = 1; a <= 4; a++) begin
            @(posedge sys_clk);
            issue(1, 24'h10_0000, a[3:0]);
            settle();
            rd(8'h80, {MMAG_ITR_CPU, MMAG_TGC_NONE});
            rd(8'h81, {a[3:0], MMAG_ERR_ILLEGAL});
            clr();
        end
    endtask

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial begin
        repeat (5) @(posedge sys_clk);
        reset <= 1'b0;
        repeat (4) @(posedge sys_clk);
        t_regs();
        $display("regs done");
        t_mode();
        $display("mode done");
        t_pin();
        $display("pin done");
        t_route();
        $display("route done");
        t_stop();
        $display("stop done");
        t_viol();
        $display("violation done");
        close_out();
    end
    // all tests take well under a thousand cycles
    initial begin
        repeat (5000) @(posedge sys_clk);
        err_total++;
        close_out();
    end
endmodule

bind mmag_top mmag_chk #(.NMST(NMST), .NTGT(NTGT)) chk (.sys_clk(sys_clk), .reset(reset),
    .reset_pin_n(reset_pin_n), .stop_mode(stop_mode), .mst_req(mst_req), .mst_gnt(mst_gnt),
    .mst_err(mst_err), .ecc_err(ecc_err), .tgt_req(tgt_req),
    .machine_exception(machine_exception), .normal_mode(normal_mode), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata));
`default_nettype wire
